/* File: pra_pkg.sv */
// constants and helpers shared by both ends of the process-image register channel
//
// What this block does
// - control bit 7 switches register access on
// - control bit 6 set writes, clear reads
// - control bits 5..0 give register number
// - read acknowledged by echoing control byte
// - read returns register value, high byte first
// - write acknowledged with bit 6 cleared
// - controller ignores input word after write
// - terminal ignores output word during reads
// - write value sits in output word, high first
// - only register 31 writable while protected
// - code 0x1235 in register 31 unlocks
// - other value relocks; register 31 reads back
// - written values apply after power cycle
// - register 9 returns two-character firmware revision
// - register 32 holds writable feature word
`default_nettype none

package pra_pkg;

  // ----------------------------------------
  // process image layout
  // ----------------------------------------
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int REGNUM_W = 6;
  localparam int REG_COUNT = 64;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_DIR_BIT = 6;

  // ----------------------------------------
  // terminal register map
  // ----------------------------------------
  localparam logic [5:0] REG_FW_REV = 6'h09;
  localparam logic [5:0] REG_UNLOCK = 6'h1F;
  localparam logic [5:0] REG_FEATURE = 6'h20;
  localparam logic [15:0] UNLOCK_CODE = 16'h1235;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [15:0] FEATURE_RST = 16'h0000;

  // ----------------------------------------
  // controller software registers
  // ----------------------------------------
  localparam int SW_ADDR_W = 2;
  localparam logic [1:0] OFS_CMD = 2'h0;
  localparam logic [1:0] OFS_WDATA = 2'h1;
  localparam logic [1:0] OFS_STAT = 2'h2;
  localparam logic [1:0] OFS_RDATA = 2'h3;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ACK_LSB = 8;

  // expected status byte for a given control byte
  function automatic logic [7:0] pra_ack(input logic [7:0] ctrl);
    logic [7:0] ack;
    ack = ctrl;
    if (ctrl[CTRL_DIR_BIT]) begin
      ack[CTRL_DIR_BIT] = 1'b0;
    end
    return ack;
  endfunction

endpackage

`default_nettype wire

/* File: pra_if.sv */
// process image between the coupler and the terminal
`default_nettype none

interface pra_if;
  logic [pra_pkg::BYTE_W-1:0] ctrlByte;
  logic [pra_pkg::WORD_W-1:0] requestWord;
  logic [pra_pkg::BYTE_W-1:0] statusByte;
  logic [pra_pkg::WORD_W-1:0] responseWord;

  modport dev (
    input ctrlByte,
    input requestWord,
    output statusByte,
    output responseWord
  );

  modport ctl (
    output ctrlByte,
    output requestWord,
    input statusByte,
    input responseWord
  );
endinterface

`default_nettype wire

/* File: pra_terminal.sv */
// terminal end: register access carried in the cyclic process image
`default_nettype none

module pra_terminal #(
  // arbitrary revision, two printable characters "1B"
  parameter logic [15:0] FW_REVISION = 16'h3142
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // process image
  pra_if.dev link,
  // restart of the terminal, one-cycle pulse
  input wire logic powerCycle,
  // state shown to the terminal's own logic
  output logic [pra_pkg::WORD_W-1:0] featureActive,
  output logic writeUnlocked,
  output logic writeRefused
);
  import pra_pkg::*;

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (FW_REVISION[15:8] < 8'h20 || FW_REVISION[15:8] > 8'h7E ||
      FW_REVISION[7:0] < 8'h20 || FW_REVISION[7:0] > 8'h7E) begin : gBadRev
    $error("firmware revision must be two printable characters");
  end

  // the staged array is indexed by the full register number
  if (REG_COUNT != 2 ** REGNUM_W || WORD_W != 2 * BYTE_W) begin : gBadMap
    $error("register map does not fit the process image layout");
  end

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [WORD_W-1:0] staged_r [REG_COUNT];
  logic [WORD_W-1:0] featureActive_r;
  logic unlock_r;
  logic writeRefused_r;
  logic [BYTE_W-1:0] prevCtrl_r;
  logic [BYTE_W-1:0] status_r;
  logic [WORD_W-1:0] response_r;

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  logic accessOn;
  logic newReq;
  logic isWrite;
  logic [REGNUM_W-1:0] regNum;
  logic writable;
  logic doWrite;
  logic doRead;

  // register mode only while the enable bit stands
  assign accessOn = link.ctrlByte[CTRL_EN_BIT];

  // a repeated control byte is the same request still pending
  assign newReq = accessOn && (link.ctrlByte != prevCtrl_r);

  assign isWrite = link.ctrlByte[CTRL_DIR_BIT];

  assign regNum = link.ctrlByte[REGNUM_W-1:0];

  // code-word register always open, revision never
  always_comb begin
    writable = 1'b0;
    if (regNum == REG_UNLOCK) begin
      writable = 1'b1;
    end else if (regNum == REG_FW_REV) begin
      writable = 1'b0;
    end else begin
      writable = unlock_r;
    end
  end

  // work is done only on the edge that brings a new control byte
  assign doWrite = newReq && isWrite;
  assign doRead = newReq && !isWrite;

  // ----------------------------------------
  // read multiplexer
  // ----------------------------------------
  // revision comes from the parameter; its array slot stays unused
  function automatic logic [WORD_W-1:0] readValue(
    input logic [REGNUM_W-1:0] num,
    input logic [WORD_W-1:0] stored
  );
    logic [WORD_W-1:0] val;
    val = stored;
    if (num == REG_FW_REV) begin
      val = FW_REVISION;
    end
    return val;
  endfunction

  // ----------------------------------------
  // previous control byte
  // ----------------------------------------
  // cleared by reset so that the first request after it counts as new
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prevCtrl_r <= 8'h00;
    end else begin
      prevCtrl_r <= link.ctrlByte;
    end
  end

  // ----------------------------------------
  // status byte
  // ----------------------------------------
  // dropped whenever register mode is off, so the far side sees the release
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= 8'h00;
    end else if (!accessOn) begin
      status_r <= 8'h00;
    end else if (doWrite) begin
      status_r <= pra_ack(link.ctrlByte);
    end else if (doRead) begin
      status_r <= link.ctrlByte;
    end
  end

  // ----------------------------------------
  // input word
  // ----------------------------------------
  // left as it was after a write: the far side must not use it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      response_r <= 16'h0000;
    end else if (!accessOn) begin
      response_r <= 16'h0000;
    end else if (doRead) begin
      // output word not looked at on a read
      response_r <= readValue(regNum, staged_r[regNum]);
    end
  end

  // ----------------------------------------
  // write protection
  // ----------------------------------------
  // acts at once, unlike the stored values
  // a refused write elsewhere never moves the gate
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      unlock_r <= 1'b0;
    end else if (doWrite && regNum == REG_UNLOCK) begin
      unlock_r <= (link.requestWord == UNLOCK_CODE);
    end
  end

  // ----------------------------------------
  // staged register contents
  // ----------------------------------------
  // a refused write is still acknowledged; only the array is left alone
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        staged_r[i] <= REG_RST;
      end
      staged_r[REG_FEATURE] <= FEATURE_RST;
    end else if (doWrite && writable) begin
      // register 31 reads back as written
      staged_r[regNum] <= link.requestWord;
    end
  end

  // ----------------------------------------
  // refused write pulse
  // ----------------------------------------
  // one pulse per refused request; a repeated control byte adds none
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      writeRefused_r <= 1'b0;
    end else begin
      writeRefused_r <= doWrite && !writable;
    end
  end

  // ----------------------------------------
  // values in force
  // ----------------------------------------
  // terminal behaviour changes only on restart, never mid-run
  // the unlock flag is not touched here: it is the gate, not a setting
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      featureActive_r <= FEATURE_RST;
    end else if (powerCycle) begin
      featureActive_r <= staged_r[REG_FEATURE];
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every output is a register of its own
  assign link.statusByte = status_r;
  assign link.responseWord = response_r;
  assign featureActive = featureActive_r;
  assign writeUnlocked = unlock_r;
  assign writeRefused = writeRefused_r;

endmodule

`default_nettype wire

/* File: pra_coupler.sv */
// coupler end: runs one register access per software command
`default_nettype none

module pra_coupler (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // software port
  input wire logic [pra_pkg::SW_ADDR_W-1:0] swAddr,
  input wire logic [pra_pkg::WORD_W-1:0] swWdata,
  input wire logic swWrite,
  input wire logic swRead,
  output logic [pra_pkg::WORD_W-1:0] swRdata,
  // process image
  pra_if.ctl link
);
  import pra_pkg::*;

  typedef enum logic [1:0] {IDLE, REQ, REL} pra_state_t;

  pra_state_t state_r;
  logic [BYTE_W-1:0] ctrl_r;
  logic [WORD_W-1:0] word_r;
  logic [WORD_W-1:0] wdata_r;
  logic [WORD_W-1:0] rdata_r;
  logic [BYTE_W-1:0] ackSeen_r;
  logic done_r;
  logic [WORD_W-1:0] swRdata_r;
  logic startCmd;
  logic acked;

  // commands given while busy are dropped
  assign startCmd = swWrite && swAddr == OFS_CMD && state_r == IDLE;
  assign acked = link.statusByte == pra_ack(ctrl_r);

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  // the control byte is cleared between accesses so that a repeat counts
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= IDLE;
      ctrl_r <= 8'h00;
      word_r <= 16'h0000;
    end else begin
      case (state_r)
        IDLE: begin
          if (startCmd) begin
            ctrl_r <= {1'b1, swWdata[CTRL_DIR_BIT], swWdata[REGNUM_W-1:0]};
            word_r <= wdata_r;
            state_r <= REQ;
          end
        end
        REQ: begin
          if (acked) begin
            ctrl_r <= 8'h00;
            state_r <= REL;
          end
        end
        REL: begin
          if (!link.statusByte[CTRL_EN_BIT]) begin
            state_r <= IDLE;
          end
        end
        default: begin
          state_r <= IDLE;
          ctrl_r <= 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------
  // results
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 16'h0000;
      ackSeen_r <= 8'h00;
    end else if (state_r == REQ && acked) begin
      ackSeen_r <= link.statusByte;
      if (!ctrl_r[CTRL_DIR_BIT]) begin
        rdata_r <= link.responseWord;
      end
    end
  end

  // set wins over the software clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      done_r <= 1'b0;
    end else if (state_r == REL && !link.statusByte[CTRL_EN_BIT]) begin
      done_r <= 1'b1;
    end else if (swWrite && swAddr == OFS_STAT && swWdata[STAT_DONE_BIT]) begin
      done_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wdata_r <= 16'h0000;
    end else if (swWrite && swAddr == OFS_WDATA) begin
      wdata_r <= swWdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      swRdata_r <= 16'h0000;
    end else if (swRead) begin
      case (swAddr)
        OFS_CMD: swRdata_r <= {8'h00, ctrl_r};
        OFS_WDATA: swRdata_r <= wdata_r;
        OFS_STAT: begin
          swRdata_r <= {ackSeen_r, 6'h00, done_r, state_r != IDLE};
        end
        OFS_RDATA: swRdata_r <= rdata_r;
        default: swRdata_r <= 16'h0000;
      endcase
    end else begin
      swRdata_r <= 16'h0000;
    end
  end

  assign swRdata = swRdata_r;
  assign link.ctrlByte = ctrl_r;
  assign link.requestWord = word_r;

endmodule

`default_nettype wire

/* File: pra_asserts.sv */
// interface checker for the process-image register channel
`default_nettype none

module pra_asserts #(
  parameter logic [15:0] FW_REVISION = 16'h3142
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // process image
  input wire logic [pra_pkg::BYTE_W-1:0] ctrlByte,
  input wire logic [pra_pkg::WORD_W-1:0] requestWord,
  input wire logic [pra_pkg::BYTE_W-1:0] statusByte,
  input wire logic [pra_pkg::WORD_W-1:0] responseWord
);
  timeunit 1ns;
  timeprecision 1ps;
  import pra_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // ------
  // helpers
  // ------
  logic [7:0] prevCtrl_r;
  logic [15:0] code_r;
  wire logic newReq = ctrlByte[7] && (ctrlByte != prevCtrl_r);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prevCtrl_r <= 8'h00;
    end else begin
      prevCtrl_r <= ctrlByte;
    end
  end

  // the code register is always writable, so a plain mirror is enough
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      code_r <= 16'h0000;
    end else if (newReq && ctrlByte[6] && ctrlByte[5:0] == REG_UNLOCK) begin
      code_r <= requestWord;
    end
  end

  // ------
  // checks
  // ------
  idle_status_a: assert property (!ctrlByte[7] |=> statusByte == 8'h00)
    else $error("status byte not cleared");
  idle_word_a: assert property (!ctrlByte[7] |=> responseWord == 16'h0000)
    else $error("input word not cleared");
  read_echo_a: assert property (newReq && !ctrlByte[6] |=> statusByte == $past(ctrlByte))
    else $error("read not echoed");
  write_ack_a: assert property (newReq && ctrlByte[6] |=> statusByte == ($past(ctrlByte) & 8'hBF))
    else $error("write ack wrong");
  fw_read_a: assert property (newReq && ctrlByte == {2'b10, REG_FW_REV}
    |=> responseWord == FW_REVISION)
    else $error("revision wrong");
  code_read_a: assert property (newReq && ctrlByte == {2'b10, REG_UNLOCK}
    |=> responseWord == code_r)
    else $error("code register readback wrong");
  ack_hold_a: assert property (ctrlByte[7] && $stable(ctrlByte) |=> $stable(statusByte))
    else $error("ack not held");
  read_hold_a: assert property (ctrlByte[7] && !ctrlByte[6] && $stable(ctrlByte)
    |=> $stable(responseWord))
    else $error("read value not held");

  cover property (newReq && ctrlByte == {2'b11, REG_UNLOCK});
  cover property (newReq && ctrlByte == {2'b10, REG_FEATURE});
  cover property (newReq && ctrlByte == {2'b10, REG_FW_REV});
endmodule

`default_nettype wire

/* File: process_image_register_access_bench.sv */
// self-checking bench joining coupler and terminal over the process image
`default_nettype none

module process_image_register_access_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pra_pkg::*;
  localparam logic [15:0] FW_REV = 16'h3758; // arbitrary, two printable characters
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] swAddr = 2'h0;
  logic [15:0] swWdata = 16'h0000;
  logic swWrite = 1'b0;
  logic swRead = 1'b0;
  logic powerCycle = 1'b0;
  logic chkRd = 1'b0;
  logic chkPend = 1'b0;
  logic [15:0] swRdata;
  logic [15:0] featureActive;
  logic writeUnlocked;
  logic writeRefused;
  logic [15:0] mdl [64];
  logic [15:0] expQ[$];
  logic [15:0] mskQ[$];
  logic [31:0] seed = 32'h0000EDF1;
  logic unl = 1'b0;
  logic [15:0] featAct = 16'h0000;
  logic [15:0] lastRd = 16'h0000;
  int numErrors = 0;
  int cmpCount = 0;
  int refSeen = 0;
  int refExp = 0;

  pra_if linkIf ();
  pra_terminal #(.FW_REVISION(FW_REV)) pra_terminal_inst (.mclk(mclk), .arst_n(arst_n),
    .link(linkIf), .powerCycle(powerCycle), .featureActive(featureActive),
    .writeUnlocked(writeUnlocked), .writeRefused(writeRefused));
  pra_coupler pra_coupler_inst (.mclk(mclk), .arst_n(arst_n), .swAddr(swAddr),
    .swWdata(swWdata), .swWrite(swWrite), .swRead(swRead), .swRdata(swRdata), .link(linkIf));
  pra_asserts #(.FW_REVISION(FW_REV)) pra_asserts_inst (.mclk(mclk), .arst_n(arst_n),
    .ctrlByte(linkIf.ctrlByte), .requestWord(linkIf.requestWord),
    .statusByte(linkIf.statusByte), .responseWord(linkIf.responseWord));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] msk);
    cmpCount++;
    if ((got & msk) !== (exp & msk)) begin
      numErrors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stopTest();
    $display("errors %0d comparisons %0d", numErrors, cmpCount);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge mclk) begin
    if (chkPend) begin
      check(swRdata, expQ.pop_front(), mskQ.pop_front());
    end
    chkPend <= swRead && chkRd;
    if (writeRefused === 1'b1) begin
      refSeen++;
    end
  end

  task automatic note(input logic [15:0] e, input logic [15:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
  endtask

  // one strobe, then an idle cycle so no signal is set twice in a step
  task automatic sw(input logic w, input logic [1:0] a, input logic [15:0] d, input logic c,
                    output logic [15:0] rd);
    swWrite <= w;
    swRead <= !w;
    swAddr <= a;
    swWdata <= d;
    chkRd <= c;
    @(posedge mclk);
    swWrite <= 1'b0;
    swRead <= 1'b0;
    @(posedge mclk);
    rd = swRdata;
  endtask

  task automatic acc(input logic w, input logic [5:0] r, input logic [15:0] d);
    logic [15:0] rd;
    int n;
    n = 0;
    sw(1'b1, OFS_WDATA, d, 1'b0, rd);
    note(d, 16'hFFFF);
    sw(1'b0, OFS_WDATA, 16'h0000, 1'b1, rd);
    sw(1'b1, OFS_CMD, {9'h000, w, r}, 1'b0, rd);
    // taken at the ack edge, the control byte still stands
    note({9'h001, w, r}, 16'hFFFF);
    sw(1'b0, OFS_CMD, 16'h0000, 1'b1, rd);
    do begin
      sw(1'b0, OFS_STAT, 16'h0000, 1'b0, rd);
      n++;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 20);
    if (rd[STAT_BUSY_BIT] !== 1'b0) begin
      numErrors++;
      $display("[FAIL] %0t access never finished", $time);
      stopTest();
    end
    note({2'b10, r, 8'h02}, 16'hFF03);
    sw(1'b0, OFS_STAT, 16'h0000, 1'b1, rd);
    sw(1'b1, OFS_STAT, 16'h0002, 1'b0, rd);
    note({2'b10, r, 8'h00}, 16'hFF03);
    sw(1'b0, OFS_STAT, 16'h0000, 1'b1, rd);
    if (w) begin
      if (r == REG_UNLOCK || (unl && r != REG_FW_REV)) begin
        mdl[r] = d;
      end else begin
        refExp++;
      end
      if (r == REG_UNLOCK) begin
        unl = (d == UNLOCK_CODE);
      end
    end else begin
      lastRd = (r == REG_FW_REV) ? FW_REV : mdl[r];
    end
    // after a write the read value must not move
    note(lastRd, 16'hFFFF);
    sw(1'b0, OFS_RDATA, 16'h0000, 1'b1, rd);
    check({15'h0000, writeUnlocked}, {15'h0000, unl}, 16'h0001);
    check(featureActive, featAct, 16'hFFFF);
    check(16'(refSeen), 16'(refExp), 16'hFFFF);
  endtask

  task automatic pulse();
    powerCycle <= 1'b1;
    @(posedge mclk);
    powerCycle <= 1'b0;
    featAct = mdl[REG_FEATURE];
    @(posedge mclk);
  endtask

  task automatic doReset();
    arst_n <= 1'b0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    foreach (mdl[i]) mdl[i] = 16'h0000;
    unl = 1'b0;
    featAct = 16'h0000;
    lastRd = 16'h0000;
    refExp = 0;
    refSeen = 0;
  endtask

  initial begin
    logic [15:0] rd;
    logic [5:0] r;
    int k;
    doReset();
    acc(1'b0, REG_FW_REV, 16'hA5A5);
    acc(1'b1, REG_FEATURE, 16'h0002);
    acc(1'b1, REG_UNLOCK, UNLOCK_CODE);
    acc(1'b0, REG_UNLOCK, 16'h5A5A);
    acc(1'b1, REG_FEATURE, 16'h0002);
    acc(1'b0, REG_FEATURE, 16'hFFFF);
    pulse();
    acc(1'b1, REG_FW_REV, 16'h1111);
    for (k = 0; k < 200; k++) begin
      seed = xs(seed);
      r = seed[13] ? seed[5:0] : (seed[12] ? REG_UNLOCK : REG_FEATURE);
      acc(seed[6], r, seed[7] ? UNLOCK_CODE : seed[31:16]);
      if (seed[8] && seed[9]) begin
        pulse();
      end
    end
    // abort an unlock in flight: reset must leave protection on
    sw(1'b1, OFS_WDATA, UNLOCK_CODE, 1'b0, rd);
    sw(1'b1, OFS_CMD, {10'h001, REG_UNLOCK}, 1'b0, rd);
    doReset();
    acc(1'b1, REG_FEATURE, 16'h00F0);
    acc(1'b0, REG_FEATURE, 16'h0000);
    stopTest();
  end
endmodule

`default_nettype wire
